/* rct_pkg.sv */
package rct_pkg;
   localparam logic [2:0] RCT_SUBADDR       = 3'h2;
   localparam int         RCT_SUB_LSB       = 1;
   localparam int         RCT_RW_BIT        = 0;
   localparam logic [7:0] RCT_ID_SERVO_CUT  = 8'h24;
   localparam logic [7:0] RCT_ID_DATA_BOOST = 8'h34;
   localparam logic [7:0] RCT_ID_SERVO_BST  = 8'h44;
   localparam logic [7:0] RCT_ID_VITERBI    = 8'h54;
   localparam logic [7:0] RCT_ID_LEVEL      = 8'h64;
   localparam int         RCT_TOP_BIT       = 7;
   localparam int         RCT_SBOOST_LSB    = 6;
   localparam int         RCT_GD_SIGN_BIT   = 5;
   localparam logic [7:0] RCT_RST_SERVO_CUT = 8'h00;
   localparam logic [7:0] RCT_RST_DATA_BST  = 8'h00;
   localparam logic [7:0] RCT_RST_SERVO_BST = 8'h00;
   localparam logic [7:0] RCT_RST_VITERBI   = 8'h00;
   localparam logic [5:0] RCT_RST_LEVEL     = 6'h00;
   localparam logic [6:0] RCT_SCUT_MIN      = 7'h0E;
   localparam logic [6:0] RCT_SCUT_MAX      = 7'h2B;
   localparam logic [6:0] RCT_DCUT_MIN      = 7'h2C;
   localparam logic [6:0] RCT_DCUT_MAX      = 7'h75;
   localparam logic [6:0] RCT_VIT_MIN       = 7'h2D;
   localparam logic [5:0] RCT_LEVEL_MIN     = 6'h10;
   // scaled fixed point: ppm for boost, 1e-4 for delay, uV, milli-percent, 10 kHz x 1e-3
   localparam int         RCT_BOOST_K1      = 21848;
   localparam int         RCT_BOOST_K2      = 46;
   localparam int         RCT_GD_SLOPE      = 9783;
   localparam int         RCT_GD_OFFSET     = -6650;
   localparam int         RCT_LVL_PRE_UV    = 10470;
   localparam int         RCT_LVL_POST_UV   = 7440;
   localparam int         RCT_LVL_PCT_M     = 1574;
   localparam int         RCT_VIT_UV        = 7874;
   localparam int         RCT_SCUT_SLOPE    = 2770;
   localparam int         RCT_SCUT_OFFSET   = 802;
   localparam int         RCT_DCUT_SLOPE    = 301;
   localparam int         RCT_DCUT_OFFSET   = -1142;
endpackage

/* rct_lin.sv */
`timescale 1ns/1ps
// registered linear map: value = slope * code + offset
module rct_lin #(
   parameter int W_CODE = 7,
   parameter int W_OUT  = 21,
   parameter int SLOPE  = 1,
   parameter int OFFSET = 0
) (
   input  wire logic                     clk,
   input  wire logic                     resetn,
   input  wire logic        [W_CODE-1:0] code,
   output logic signed      [W_OUT-1:0]  value
);
   typedef struct packed {
      logic signed [W_OUT-1:0] value;
   } rct_lin_s;

   rct_lin_s state_reg;
   rct_lin_s state_next;

   always_comb begin
      int full;
      full = SLOPE * int'(code) + OFFSET;
      state_next = state_reg;
      state_next.value = W_OUT'(full);
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign value = state_reg.value;
endmodule // rct_lin

/* rct_regs.sv */
`timescale 1ns/1ps
module rct_regs
   import rct_pkg::*;
(
   input  wire logic               clk,
   input  wire logic               resetn,
   input  wire logic               cmd_valid,
   input  wire logic        [7:0]  cmd_id,
   input  wire logic        [7:0]  cmd_wdata,
   output logic                    cmd_ack,
   output logic                    cmd_miss,
   output logic             [7:0]  cmd_rdata,
   input  wire logic        [6:0]  data_cutoff_code,
   input  wire logic               sync_field_detect_point,
   input  wire logic               precomp_level_config,
   output logic                    servo_qualifier_select,
   output logic             [6:0]  servo_cutoff_code,
   output logic                    servo_cutoff_ok,
   output logic signed      [20:0] servo_cutoff_scaled,
   output logic signed      [20:0] data_cutoff_scaled,
   output logic                    data_cutoff_ok,
   output logic                    lowz_time_ratio,
   output logic             [6:0]  data_boost_code,
   output logic             [22:0] data_boost_linear,
   output logic             [1:0]  servo_boost_step,
   output logic             [2:0]  servo_boost_db,
   output logic             [5:0]  group_delay_trim,
   output logic signed      [20:0] group_delay_scaled,
   output logic                    survivor_path_skip,
   output logic             [6:0]  viterbi_qualify_limit,
   output logic                    viterbi_limit_ok,
   output logic signed      [20:0] viterbi_limit_uv,
   output logic             [5:0]  data_level_code,
   output logic             [19:0] data_level_scaled,
   output logic                    data_level_is_pct,
   output logic                    data_level_ok
);
   typedef struct packed {
      logic [7:0]         servo_cut;
      logic [7:0]         data_boost;
      logic [7:0]         servo_boost;
      logic [7:0]         viterbi;
      logic [5:0]         level;
      logic               ack;
      logic               miss;
      logic [7:0]         rdata;
      logic [22:0]        boost_lin;
      logic [2:0]         boost_db;
      logic signed [20:0] gd;
      logic [19:0]        level_val;
      logic               level_pct;
      logic               scut_ok;
      logic               dcut_ok;
      logic               vit_ok;
      logic               level_ok;
   } rct_state_s;

   rct_state_s state_reg;
   rct_state_s state_next;

   logic signed [20:0] gd_mag_scaled;
   logic signed [20:0] lvl_pre;
   logic signed [20:0] lvl_post;
   logic signed [20:0] lvl_pct;

   // id decode: sub-address must match, bit 0 high means read
   logic       id_sub_ok;
   logic [7:0] id_base;
   logic       is_read;
   logic       hit;

   assign id_sub_ok = (cmd_id[RCT_SUB_LSB +: 3] == RCT_SUBADDR);
   assign id_base   = {cmd_id[7:1], 1'b0};
   assign is_read   = cmd_id[RCT_RW_BIT];

   always_comb begin
      hit = 1'b0;
      if (id_sub_ok) begin
         case (id_base)
            RCT_ID_SERVO_CUT,
            RCT_ID_DATA_BOOST,
            RCT_ID_SERVO_BST,
            RCT_ID_VITERBI,
            RCT_ID_LEVEL: hit = 1'b1;
            default: hit = 1'b0;
         endcase
      end
   end

   rct_lin #(.W_CODE(7), .W_OUT(21), .SLOPE(RCT_SCUT_SLOPE), .OFFSET(RCT_SCUT_OFFSET)) u_scut (
      .clk    (clk),
      .resetn (resetn),
      .code   (state_reg.servo_cut[6:0]),
      .value  (servo_cutoff_scaled)
   );

   rct_lin #(.W_CODE(7), .W_OUT(21), .SLOPE(RCT_DCUT_SLOPE), .OFFSET(RCT_DCUT_OFFSET)) u_dcut (
      .clk    (clk),
      .resetn (resetn),
      .code   (data_cutoff_code),
      .value  (data_cutoff_scaled)
   );

   rct_lin #(.W_CODE(5), .W_OUT(21), .SLOPE(RCT_GD_SLOPE), .OFFSET(RCT_GD_OFFSET)) u_gd (
      .clk    (clk),
      .resetn (resetn),
      .code   (state_reg.servo_boost[4:0]),
      .value  (gd_mag_scaled)
   );

   rct_lin #(.W_CODE(7), .W_OUT(21), .SLOPE(RCT_VIT_UV), .OFFSET(0)) u_vit (
      .clk    (clk),
      .resetn (resetn),
      .code   (state_reg.viterbi[6:0]),
      .value  (viterbi_limit_uv)
   );

   rct_lin #(.W_CODE(6), .W_OUT(21), .SLOPE(RCT_LVL_PRE_UV), .OFFSET(0)) u_lvl_pre (
      .clk    (clk),
      .resetn (resetn),
      .code   (state_reg.level),
      .value  (lvl_pre)
   );

   rct_lin #(.W_CODE(6), .W_OUT(21), .SLOPE(RCT_LVL_POST_UV), .OFFSET(0)) u_lvl_post (
      .clk    (clk),
      .resetn (resetn),
      .code   (state_reg.level),
      .value  (lvl_post)
   );

   rct_lin #(.W_CODE(6), .W_OUT(21), .SLOPE(RCT_LVL_PCT_M), .OFFSET(0)) u_lvl_pct (
      .clk    (clk),
      .resetn (resetn),
      .code   (state_reg.level),
      .value  (lvl_pct)
   );

   always_comb begin
      int boost_full;
      boost_full = 0;
      state_next = state_reg;
      state_next.ack  = 1'b0;
      state_next.miss = 1'b0;

      // host port: every valid is answered next cycle, misses read as zero
      if (cmd_valid) begin
         state_next.ack   = 1'b1;
         state_next.miss  = ~hit;
         state_next.rdata = 8'h00;
         if (hit && is_read) begin
            case (id_base)
               RCT_ID_SERVO_CUT:  state_next.rdata = state_reg.servo_cut;
               RCT_ID_DATA_BOOST: state_next.rdata = state_reg.data_boost;
               RCT_ID_SERVO_BST:  state_next.rdata = state_reg.servo_boost;
               RCT_ID_VITERBI:    state_next.rdata = state_reg.viterbi;
               RCT_ID_LEVEL:      state_next.rdata = {2'b00, state_reg.level};
               default:           state_next.rdata = 8'h00;
            endcase
         end else if (hit) begin
            case (id_base)
               RCT_ID_SERVO_CUT:  state_next.servo_cut   = cmd_wdata;
               RCT_ID_DATA_BOOST: state_next.data_boost  = cmd_wdata;
               RCT_ID_SERVO_BST:  state_next.servo_boost = cmd_wdata;
               RCT_ID_VITERBI:    state_next.viterbi     = cmd_wdata;
               // unused top bits are dropped, they read back as zero
               RCT_ID_LEVEL:      state_next.level       = cmd_wdata[5:0];
               default:           state_next.level       = state_reg.level;
            endcase
         end
      end

      // boost depends on both its own code and the live data cutoff code
      boost_full = int'(state_reg.data_boost[6:0]) *
                   (RCT_BOOST_K1 + RCT_BOOST_K2 * int'(data_cutoff_code));
      state_next.boost_lin = 23'(boost_full);

      state_next.boost_db = {state_reg.servo_boost[RCT_SBOOST_LSB +: 2], 1'b0};

      // sign-magnitude: bit five set keeps the term positive
      if (state_reg.servo_boost[RCT_GD_SIGN_BIT]) begin
         state_next.gd = gd_mag_scaled;
      end else begin
         state_next.gd = -gd_mag_scaled;
      end

      // adaptive before sync has no percentage form, fixed scale is kept
      if (precomp_level_config && sync_field_detect_point) begin
         state_next.level_val = lvl_pct[19:0];
         state_next.level_pct = 1'b1;
      end else if (sync_field_detect_point) begin
         state_next.level_val = lvl_post[19:0];
         state_next.level_pct = 1'b0;
      end else begin
         state_next.level_val = lvl_pre[19:0];
         state_next.level_pct = 1'b0;
      end

      state_next.scut_ok  = (state_reg.servo_cut[6:0] >= RCT_SCUT_MIN) &&
                            (state_reg.servo_cut[6:0] <= RCT_SCUT_MAX);
      state_next.dcut_ok  = (data_cutoff_code >= RCT_DCUT_MIN) &&
                            (data_cutoff_code <= RCT_DCUT_MAX);
      state_next.vit_ok   = (state_reg.viterbi[6:0] >= RCT_VIT_MIN);
      // out-of-range codes are flagged only, the host owns the limit
      state_next.level_ok = (state_reg.level >= RCT_LEVEL_MIN);
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_reg             <= '0;
         state_reg.servo_cut   <= RCT_RST_SERVO_CUT;
         state_reg.data_boost  <= RCT_RST_DATA_BST;
         state_reg.servo_boost <= RCT_RST_SERVO_BST;
         state_reg.viterbi     <= RCT_RST_VITERBI;
         state_reg.level       <= RCT_RST_LEVEL;
      end else begin
         state_reg <= state_next;
      end
   end

   assign cmd_ack                = state_reg.ack;
   assign cmd_miss               = state_reg.miss;
   assign cmd_rdata              = state_reg.rdata;
   assign servo_qualifier_select = state_reg.servo_cut[RCT_TOP_BIT];
   assign servo_cutoff_code      = state_reg.servo_cut[6:0];
   assign servo_cutoff_ok        = state_reg.scut_ok;
   assign data_cutoff_ok         = state_reg.dcut_ok;
   assign lowz_time_ratio        = state_reg.data_boost[RCT_TOP_BIT];
   assign data_boost_code        = state_reg.data_boost[6:0];
   assign data_boost_linear      = state_reg.boost_lin;
   assign servo_boost_step       = state_reg.servo_boost[RCT_SBOOST_LSB +: 2];
   assign servo_boost_db         = state_reg.boost_db;
   assign group_delay_trim       = state_reg.servo_boost[5:0];
   assign group_delay_scaled     = state_reg.gd;
   assign survivor_path_skip     = state_reg.viterbi[RCT_TOP_BIT];
   assign viterbi_qualify_limit  = state_reg.viterbi[6:0];
   assign viterbi_limit_ok       = state_reg.vit_ok;
   assign data_level_code        = state_reg.level;
   assign data_level_scaled      = state_reg.level_val;
   assign data_level_is_pct      = state_reg.level_pct;
   assign data_level_ok          = state_reg.level_ok;
endmodule // rct_regs

/* rct_regs_props.sv */
`timescale 1ns/1ps
module rct_regs_chk
   import rct_pkg::*;
(
   input wire logic       clk,
   input wire logic       resetn,
   input wire logic       cmd_valid,
   input wire logic [7:0] cmd_id,
   input wire logic [7:0] cmd_wdata,
   input wire logic       cmd_ack,
   input wire logic       cmd_miss,
   input wire logic [7:0] cmd_rdata,
   input wire logic       sync_field_detect_point,
   input wire logic       precomp_level_config,
   input wire logic       servo_qualifier_select,
   input wire logic [6:0] data_boost_code,
   input wire logic [1:0] servo_boost_step,
   input wire logic [2:0] servo_boost_db,
   input wire logic [5:0] group_delay_trim,
   input wire logic       survivor_path_skip,
   input wire logic [5:0] data_level_code,
   input wire logic       data_level_is_pct
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   // a write with a bad sub-address is refused, so it must not arm the field checks
   wire wr_en = cmd_valid && !cmd_id[0] && (cmd_id[3:1] == RCT_SUBADDR);
   property p_ack; cmd_valid |=> cmd_ack; endproperty
   a_ack: assert property (p_ack) else $error("request not answered");
   property p_quiet; !cmd_valid |=> !cmd_ack && !cmd_miss; endproperty
   a_quiet: assert property (p_quiet) else $error("answer without request");
   property p_miss; cmd_valid && cmd_id[3:1] != RCT_SUBADDR |=> cmd_miss && cmd_rdata == 8'h00; endproperty
   a_miss: assert property (p_miss) else $error("bad id not refused");
   property p_rd44; cmd_valid && cmd_id == 8'h45 |=> cmd_rdata == {servo_boost_step, group_delay_trim}; endproperty
   a_rd44: assert property (p_rd44) else $error("readback differs from fields");
   property p_db; 1 |=> servo_boost_db == {$past(servo_boost_step), 1'b0}; endproperty
   a_db: assert property (p_db) else $error("servo boost step decode wrong");
   property p_boost; wr_en && cmd_id[7:4] == 4'h3 |=> data_boost_code == $past(cmd_wdata[6:0]); endproperty
   a_boost: assert property (p_boost) else $error("boost code not taken");
   property p_qual; wr_en && cmd_id[7:4] == 4'h2 |=> servo_qualifier_select == $past(cmd_wdata[7]); endproperty
   a_qual: assert property (p_qual) else $error("qualifier select not taken");
   property p_skip; wr_en && cmd_id[7:4] == 4'h5 |=> survivor_path_skip == $past(cmd_wdata[7]); endproperty
   a_skip: assert property (p_skip) else $error("survivor skip not taken");
   property p_lvl; wr_en && cmd_id[7:4] == 4'h6 |=> data_level_code == $past(cmd_wdata[5:0]); endproperty
   a_lvl: assert property (p_lvl) else $error("level code not taken");
   property p_pct; 1 |=> data_level_is_pct == $past(sync_field_detect_point && precomp_level_config); endproperty
   a_pct: assert property (p_pct) else $error("level mode wrong");
   c_wr: cover property (wr_en);
   c_rd: cover property (cmd_valid && cmd_id[0]);
   c_miss: cover property (cmd_ack && cmd_miss);
endmodule // rct_regs_chk

bind rct_regs rct_regs_chk u_chk (.clk(clk), .resetn(resetn), .cmd_valid(cmd_valid), .cmd_id(cmd_id),
   .cmd_wdata(cmd_wdata), .cmd_ack(cmd_ack), .cmd_miss(cmd_miss), .cmd_rdata(cmd_rdata),
   .sync_field_detect_point(sync_field_detect_point), .precomp_level_config(precomp_level_config),
   .servo_qualifier_select(servo_qualifier_select), .data_boost_code(data_boost_code),
   .servo_boost_step(servo_boost_step), .servo_boost_db(servo_boost_db), .group_delay_trim(group_delay_trim),
   .survivor_path_skip(survivor_path_skip), .data_level_code(data_level_code),
   .data_level_is_pct(data_level_is_pct));

/* rct_host.sv */
`timescale 1ns/1ps
module rct_host (
   input  wire logic       clk,
   input  wire logic       cmd_ack,
   input  wire logic       cmd_miss,
   input  wire logic [7:0] cmd_rdata,
   output logic            cmd_valid,
   output logic      [7:0] cmd_id,
   output logic      [7:0] cmd_wdata
);
   initial begin
      cmd_valid = 1'b0;
      cmd_id    = 8'h00;
      cmd_wdata = 8'h00;
   end
   // call at a falling edge; strobe stays up so calls chain back to back
   task automatic xfer(input logic [7:0] id, input logic [7:0] d, output logic [9:0] ans);
      cmd_valid = 1'b1;
      cmd_id    = id;
      cmd_wdata = (id == 8'h64 && d[5:0] < 6'h10) ? {d[7:6], 6'h10} : d;
      @(negedge clk);
      ans = {cmd_ack, cmd_miss, cmd_rdata};
   endtask
   // idle lines never keep the last value, so stale data cannot pass
   task automatic idle();
      cmd_valid = 1'b0;
      cmd_id    = ~cmd_id;
      cmd_wdata = ~cmd_wdata;
      @(negedge clk);
   endtask
endmodule // rct_host

/* tb.sv */
`timescale 1ns/1ps
module tb;
   import rct_pkg::*;
   logic clk, resetn, cmd_valid, cmd_ack, cmd_miss, sync_field_detect_point, precomp_level_config;
   logic servo_qualifier_select, lowz_time_ratio, survivor_path_skip, data_level_is_pct, data_cutoff_ok;
   logic [7:0] cmd_id, cmd_wdata, cmd_rdata;
   logic [6:0] data_cutoff_code, servo_cutoff_code, data_boost_code, viterbi_qualify_limit;
   logic [5:0] group_delay_trim, data_level_code;
   logic [1:0] servo_boost_step;
   logic [2:0] servo_boost_db;
   logic [22:0] data_boost_linear;
   logic [19:0] data_level_scaled;
   logic signed [20:0] data_cutoff_scaled, group_delay_scaled, viterbi_limit_uv, servo_cutoff_scaled;
   logic servo_cutoff_ok, viterbi_limit_ok, data_level_ok;
   logic [9:0] ans;
   logic [7:0] wv [5] = '{8'h9F, 8'hD5, 8'hE5, 8'hAD, 8'hFF};
   int err_count = 0;
   int checks_done = 0;
   rct_regs DUT (.clk(clk), .resetn(resetn), .cmd_valid(cmd_valid), .cmd_id(cmd_id), .cmd_wdata(cmd_wdata),
      .cmd_ack(cmd_ack), .cmd_miss(cmd_miss), .cmd_rdata(cmd_rdata), .data_cutoff_code(data_cutoff_code),
      .sync_field_detect_point(sync_field_detect_point), .precomp_level_config(precomp_level_config),
      .servo_qualifier_select(servo_qualifier_select), .servo_cutoff_code(servo_cutoff_code),
      .servo_cutoff_ok(servo_cutoff_ok), .servo_cutoff_scaled(servo_cutoff_scaled),
      .data_cutoff_scaled(data_cutoff_scaled),
      .data_cutoff_ok(data_cutoff_ok), .lowz_time_ratio(lowz_time_ratio), .data_boost_code(data_boost_code),
      .data_boost_linear(data_boost_linear), .servo_boost_step(servo_boost_step), .servo_boost_db(servo_boost_db),
      .group_delay_trim(group_delay_trim), .group_delay_scaled(group_delay_scaled),
      .survivor_path_skip(survivor_path_skip), .viterbi_qualify_limit(viterbi_qualify_limit),
      .viterbi_limit_ok(viterbi_limit_ok), .viterbi_limit_uv(viterbi_limit_uv), .data_level_code(data_level_code),
      .data_level_scaled(data_level_scaled), .data_level_is_pct(data_level_is_pct), .data_level_ok(data_level_ok));
   rct_host host (.clk(clk), .cmd_ack(cmd_ack), .cmd_miss(cmd_miss), .cmd_rdata(cmd_rdata),
      .cmd_valid(cmd_valid), .cmd_id(cmd_id), .cmd_wdata(cmd_wdata));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t seen=%0h exp=%0h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up();
      $display("mismatches=%0d checks=%0d", err_count, checks_done);
      if (err_count == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // about eighty cycles are needed; this leaves wide margin
   initial begin
      #50us;
      err_count++;
      wrap_up();
   end
   initial begin
      resetn = 1'b0;
      data_cutoff_code = 7'h2C;
      sync_field_detect_point = 1'b0;
      precomp_level_config = 1'b0;
      repeat (16) @(negedge clk);
      resetn = 1'b1;
      @(negedge clk);
      chk({servo_cutoff_ok, viterbi_limit_ok, data_level_ok}, 3'b000);
      for (int i = 0; i < 5; i++) begin
         host.xfer(8'h25 + 8'(16 * i), 8'h00, ans);
         chk(ans, 10'h200);
      end
      for (int i = 0; i < 5; i++) begin
         host.xfer(8'h24 + 8'(16 * i), wv[i], ans);
         chk(ans, 10'h200);
      end
      host.xfer(8'h26, 8'h00, ans);
      chk(ans, 10'h300);
      host.xfer(8'h74, 8'h00, ans);
      chk(ans, 10'h300);
      for (int i = 0; i < 5; i++) begin
         host.xfer(8'h25 + 8'(16 * i), 8'h00, ans);
         chk(ans, {2'b10, wv[i] & (i == 4 ? 8'h3F : 8'hFF)});
      end
      host.idle();
      repeat (3) @(negedge clk);
      chk({servo_qualifier_select, servo_cutoff_code}, 8'h9F);
      chk({lowz_time_ratio, data_boost_code}, 8'hD5);
      chk(data_boost_linear, 85 * (21848 + 46 * 44));
      chk(data_cutoff_scaled, 301 * 44 - 1142);
      chk(data_cutoff_ok, 1);
      chk(group_delay_scaled, 9783 * 5 - 6650);
      chk({survivor_path_skip, viterbi_qualify_limit}, 8'hAD);
      chk(viterbi_limit_uv, 7874 * 45);
      chk(servo_cutoff_scaled, 2770 * 31 + 802);
      chk({servo_cutoff_ok, viterbi_limit_ok, data_level_ok}, 3'b111);
      chk(data_level_code, 6'h3F);
      for (int m = 0; m < 4; m++) begin
         sync_field_detect_point = m[0];
         precomp_level_config = m[1];
         repeat (4) @(negedge clk);
         chk(data_level_scaled, 63 * (m == 3 ? 1574 : m[0] ? 7440 : 10470));
         chk(data_level_is_pct, m == 3);
      end
      for (int s = 0; s < 4; s++) begin
         host.xfer(8'h44, {s[1:0], s[0], 5'h05}, ans);
         host.idle();
         repeat (3) @(negedge clk);
         chk(servo_boost_db, 2 * s);
         chk({servo_boost_step, group_delay_trim}, {s[1:0], s[0], 5'h05});
         chk(group_delay_scaled, s[0] ? 42265 : -42265);
      end
      host.xfer(8'h64, 8'h05, ans);
      host.xfer(8'h65, 8'h00, ans);
      chk(ans, 10'h210);
      data_cutoff_code = 7'h76;
      repeat (3) @(negedge clk);
      chk(data_cutoff_ok, 0);
      wrap_up();
   end
endmodule // tb
